// File: rtl/dmx_regs.svh
// Constants of the data movement execution unit: register indices, steps, counts.
// Assumes register indices 0..7 are data registers and 8..15 address registers.
`ifndef DMX_REGS_SVH
`define DMX_REGS_SVH

`define DMX_STACK_INDEX 4'hF
`define DMX_LONG_STEP 32'h0000_0004
`define DMX_WORD_STEP 32'h0000_0002
`define DMX_PERIPH_LONG_BEATS 3'h4
`define DMX_PERIPH_WORD_BEATS 3'h2
`define DMX_REG_RESET 32'h0000_0000
`define DMX_BYTE_MASK 32'h0000_00FF

`endif

// File: rtl/dmx_pkg.sv
// Types shared by the data movement execution unit, its checker, memory model and test bench.
// Assumes nothing beyond a SystemVerilog elaborator.
package dmx_pkg;

  typedef enum logic [3:0] {
    OP_GENERAL   = 4'h0,
    OP_ADDR_LOAD = 4'h1,
    OP_SWAP      = 4'h2,
    OP_EA_LOAD   = 4'h3,
    OP_EA_PUSH   = 4'h4,
    OP_LINK      = 4'h5,
    OP_UNLINK    = 4'h6,
    OP_MULTI     = 4'h7,
    OP_PERIPH    = 4'h8,
    OP_QUICK     = 4'h9
  } dmx_op_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } dmx_size_e;

  // Gray sequence along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RD1  = 3'h1,
    ST_RD2  = 3'h3,
    ST_CAP  = 3'h2,
    ST_BUS  = 3'h6,
    ST_WR1  = 3'h7,
    ST_WR2  = 3'h5,
    ST_DONE = 3'h4
  } dmx_state_e;

endpackage

// File: rtl/dmx_reg_file.sv
// General register file: one write port, one read port with registered data.
// Assumes a single clock; read data reflect the index of the previous cycle.
`timescale 1ns/1ps
`include "dmx_regs.svh"

module dmx_reg_file #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic writeEn,
  input wire logic [$clog2(DEPTH)-1:0] writeIdx,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic [$clog2(DEPTH)-1:0] readIdx,
  output logic [WIDTH-1:0] readData
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_readData;

  generate
    if (DEPTH < 2 || WIDTH < 1)
    begin : g_bad
      $error("dmx_reg_file needs at least two words");
    end
  endgenerate

  // Write-through is not provided; the sequencer never reads a word it writes
  always_comb
  begin
    next_readData = mem[readIdx];
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      readData <= WIDTH'(`DMX_REG_RESET);
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= WIDTH'(`DMX_REG_RESET);
      end
    end
    else
    begin
      readData <= next_readData;
      if (writeEn)
      begin
        mem[writeIdx] <= writeData;
      end
    end
  end
endmodule

// File: rtl/dmx_data_move.sv
// Data movement execution unit: sequences register reads, bus beats and write-back.
// Assumes the caller decodes instructions and supplies computed effective addresses.
// Behaviour
// (RULE_01) General move carries byte, word or long between registers, memory, immediate.
// (RULE_02) Address load takes word or long and writes all 32 bits of An.
// (RULE_03) Swap exchanges full 32-bit contents of any two registers.
// (RULE_04) Effective-address load writes the address itself into An.
// (RULE_05) Push drops stack pointer by four, stores the address there.
// (RULE_06) Link: stack pointer minus four, store An there, An takes it, add displacement.
// (RULE_07) Unlink: stack pointer takes An, An reloads from stack top, then plus four.
// (RULE_08) Multi transfer stores or loads listed registers, word or long, 32-bit loads.
// (RULE_09) Peripheral transfer moves bytes high first at address steps of two.
// (RULE_10) Quick load writes an 8-bit immediate as 32 bits into Dn.
// (RULE_11) Quick load and word address loads sign-extend to 32 bits.
`timescale 1ns/1ps
`include "dmx_regs.svh"

module dmx_data_move #(
  parameter int DATA_WIDTH = 32,
  parameter int REG_COUNT = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire dmx_pkg::dmx_op_e opIn,
  input wire dmx_pkg::dmx_size_e sizeIn,
  input wire logic [3:0] regAIn,
  input wire logic [3:0] regBIn,
  input wire logic srcMemIn,
  input wire logic srcImmIn,
  input wire logic dstMemIn,
  input wire logic [31:0] eaSrcIn,
  input wire logic [31:0] eaDstIn,
  input wire logic [31:0] immIn,
  input wire logic [15:0] regListIn,
  output logic busy,
  output logic done,
  output logic memReq,
  output logic memWrite,
  output dmx_pkg::dmx_size_e memSize,
  output logic [31:0] memAddr,
  output logic [31:0] memWdata,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  output logic wbValid,
  output logic [3:0] wbIdx,
  output logic [31:0] wbData
);
  import dmx_pkg::*;

  generate
    if (DATA_WIDTH != 32 || REG_COUNT != 16)
    begin : g_bad
      $error("dmx_data_move serves only 32-bit data and sixteen registers");
    end
  endgenerate

  function automatic logic [31:0] sext(input logic [31:0] v, input dmx_size_e sz);
    case (sz)
      SZ_BYTE: sext = {{24{v[7]}}, v[7:0]};
      SZ_WORD: sext = {{16{v[15]}}, v[15:0]};
      default: sext = v;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] v,
                                        input dmx_size_e sz);
    case (sz)
      SZ_BYTE: merge = {old[31:8], v[7:0]};
      SZ_WORD: merge = {old[31:16], v[15:0]};
      default: merge = v;
    endcase
  endfunction

  function automatic logic [3:0] lowestSet(input logic [15:0] m);
    lowestSet = 4'h0;
    for (int i = 15; i >= 0; i--)
    begin
      if (m[i])
      begin
        lowestSet = 4'(i);
      end
    end
  endfunction

  dmx_state_e state, next_state;
  dmx_op_e op, next_op;
  dmx_size_e size, next_size;
  logic [3:0] regA, next_regA, regB, next_regB, curIdx, next_curIdx;
  logic srcMem, next_srcMem, srcImm, next_srcImm, dstMem, next_dstMem;
  logic [31:0] eaSrc, next_eaSrc, eaDst, next_eaDst, imm, next_imm;
  logic [31:0] opA, next_opA, opB, next_opB, busData, next_busData;
  logic [31:0] curAddr, next_curAddr;
  logic [15:0] mask, next_mask, remaining;
  logic [1:0] beat, next_beat, byteSel;
  logic [2:0] beatCount;
  logic next_wbValid;
  logic [3:0] next_wbIdx;
  logic [31:0] next_wbData;
  logic [3:0] readIdx, r1, r2, wr1Idx, wr2Idx;
  logic [31:0] readData, srcVal, wr1Data, wr2Data, stackDown;
  logic wr1En, wr2En, writeEn;
  logic [3:0] writeIdx;
  logic [31:0] writeData;

  dmx_reg_file #(
    .WIDTH(DATA_WIDTH),
    .DEPTH(REG_COUNT)
  ) u_regs (
    .clk_sys(clk_sys),
    .reset(reset),
    .writeEn(writeEn),
    .writeIdx(writeIdx),
    .writeData(writeData),
    .readIdx(readIdx),
    .readData(readData)
  );

  // Operand selection, bus beat shape and write-back values per operation
  always_comb
  begin
    stackDown = opA - `DMX_LONG_STEP;
    srcVal = srcMem ? busData : (srcImm ? imm : opA);
    r1 = regA;
    r2 = regB;
    beatCount = 3'h0;
    memWrite = 1'b0;
    memSize = SZ_LONG;
    memAddr = eaSrc;
    memWdata = 32'h0000_0000;
    byteSel = 2'h0;
    wr1En = 1'b0;
    wr1Idx = regB;
    wr1Data = 32'h0000_0000;
    wr2En = 1'b0;
    wr2Idx = regA;
    wr2Data = 32'h0000_0000;
    case (op)
      OP_GENERAL:
      begin
        // A memory source is read first, then a memory destination written
        beatCount = {2'h0, srcMem} + {2'h0, dstMem}; // see (RULE_01)
        memSize = size;
        memWrite = !(srcMem && beat == 2'h0);
        memAddr = memWrite ? eaDst : eaSrc;
        memWdata = srcVal;
        wr1En = !dstMem;
        wr1Data = merge(opB, srcVal, size); // see (RULE_01)
      end
      OP_ADDR_LOAD:
      begin
        beatCount = {2'h0, srcMem};
        memSize = size;
        wr1En = 1'b1;
        wr1Data = sext(srcVal, size); // see (RULE_02) see (RULE_11)
      end
      OP_SWAP:
      begin
        wr1En = 1'b1;
        wr1Idx = regA;
        wr1Data = opB; // see (RULE_03)
        wr2En = 1'b1;
        wr2Idx = regB;
        wr2Data = opA;
      end
      OP_EA_LOAD:
      begin
        wr1En = 1'b1;
        wr1Data = eaSrc; // see (RULE_04)
      end
      OP_EA_PUSH:
      begin
        r1 = `DMX_STACK_INDEX;
        beatCount = 3'h1;
        memWrite = 1'b1;
        memAddr = stackDown;
        memWdata = eaSrc; // see (RULE_05)
        wr1En = 1'b1;
        wr1Idx = `DMX_STACK_INDEX;
        wr1Data = stackDown;
      end
      OP_LINK:
      begin
        r1 = `DMX_STACK_INDEX;
        r2 = regA;
        beatCount = 3'h1;
        memWrite = 1'b1;
        memAddr = stackDown;
        memWdata = opB; // see (RULE_06)
        wr1En = 1'b1;
        wr1Idx = regA;
        wr1Data = stackDown;
        wr2En = 1'b1;
        wr2Idx = `DMX_STACK_INDEX;
        wr2Data = stackDown + imm; // see (RULE_06)
      end
      OP_UNLINK:
      begin
        beatCount = 3'h1;
        memAddr = opA; // see (RULE_07)
        wr1En = 1'b1;
        wr1Idx = `DMX_STACK_INDEX;
        wr1Data = opA + `DMX_LONG_STEP;
        wr2En = 1'b1;
        wr2Idx = regA;
        wr2Data = busData;
      end
      OP_MULTI:
      begin
        r1 = curIdx;
        beatCount = 3'h1;
        memWrite = dstMem;
        memSize = size;
        memAddr = curAddr;
        memWdata = opA; // see (RULE_08)
        wr1En = !dstMem;
        wr1Idx = curIdx;
        wr1Data = sext(busData, size);
      end
      OP_PERIPH:
      begin
        beatCount = (size == SZ_LONG) ? `DMX_PERIPH_LONG_BEATS : `DMX_PERIPH_WORD_BEATS;
        byteSel = ((size == SZ_LONG) ? 2'h3 : 2'h1) - beat;
        memWrite = dstMem;
        memSize = SZ_BYTE;
        memAddr = eaSrc + {29'h0, beat, 1'b0}; // see (RULE_09)
        memWdata = (opA >> {byteSel, 3'h0}) & `DMX_BYTE_MASK;
        wr1En = !dstMem;
        wr1Idx = regA;
        wr1Data = (size == SZ_LONG) ? busData : {opA[31:16], busData[15:0]};
      end
      OP_QUICK:
      begin
        wr1En = 1'b1;
        wr1Data = sext(imm, SZ_BYTE); // see (RULE_10) see (RULE_11)
      end
      default:
      begin
        wr1En = 1'b0;
      end
    endcase
  end

  // Sequencer
  always_comb
  begin
    next_state = state;
    next_op = op;
    next_size = size;
    next_regA = regA;
    next_regB = regB;
    next_srcMem = srcMem;
    next_srcImm = srcImm;
    next_dstMem = dstMem;
    next_eaSrc = eaSrc;
    next_eaDst = eaDst;
    next_imm = imm;
    next_opA = opA;
    next_opB = opB;
    next_busData = busData;
    next_curAddr = curAddr;
    next_curIdx = curIdx;
    next_mask = mask;
    next_beat = beat;
    remaining = mask & ~(16'h0001 << curIdx);
    readIdx = r1;
    writeEn = 1'b0;
    writeIdx = wr1Idx;
    writeData = wr1Data;
    case (state)
      ST_IDLE:
      begin
        if (start)
        begin
          next_op = opIn;
          next_size = sizeIn;
          next_regA = regAIn;
          next_regB = regBIn;
          next_srcMem = srcMemIn;
          next_srcImm = srcImmIn;
          next_dstMem = dstMemIn;
          next_eaSrc = eaSrcIn;
          next_eaDst = eaDstIn;
          next_imm = immIn;
          next_curAddr = eaSrcIn;
          next_mask = regListIn;
          next_curIdx = lowestSet(regListIn);
          next_beat = 2'h0;
          next_state = (opIn == OP_MULTI && regListIn == 16'h0000) ? ST_DONE : ST_RD1;
        end
      end
      ST_RD1:
      begin
        next_state = ST_RD2;
      end
      ST_RD2:
      begin
        readIdx = r2;
        next_opA = readData;
        next_state = ST_CAP;
      end
      ST_CAP:
      begin
        next_opB = readData;
        next_state = (beatCount != 3'h0) ? ST_BUS : ST_WR1;
      end
      ST_BUS:
      begin
        if (memAck)
        begin
          if (!memWrite)
          begin
            // Peripheral bytes arrive high first and shift in from the bottom
            next_busData = (op == OP_PERIPH) ? {busData[23:0], memRdata[7:0]} : memRdata;
          end
          next_beat = beat + 2'h1;
          if ({1'b0, beat} == beatCount - 3'h1)
          begin
            next_beat = 2'h0;
            next_state = ST_WR1;
          end
        end
      end
      ST_WR1:
      begin
        writeEn = wr1En;
        next_state = ST_WR2;
      end
      ST_WR2:
      begin
        writeEn = wr2En;
        writeIdx = wr2Idx;
        writeData = wr2Data;
        next_state = ST_DONE;
        if (op == OP_MULTI && remaining != 16'h0000)
        begin
          // Registers go in ascending index order, D0 first, A7 last
          next_mask = remaining; // see (RULE_08)
          next_curIdx = lowestSet(remaining);
          next_curAddr = curAddr + ((size == SZ_LONG) ? `DMX_LONG_STEP : `DMX_WORD_STEP);
          next_state = ST_RD1;
        end
      end
      ST_DONE:
      begin
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    next_wbValid = writeEn;
    next_wbIdx = writeEn ? writeIdx : wbIdx;
    next_wbData = writeEn ? writeData : wbData;
  end

  assign busy = (state != ST_IDLE);
  assign done = (state == ST_DONE);
  assign memReq = (state == ST_BUS);

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      op <= OP_GENERAL;
      size <= SZ_LONG;
      regA <= 4'h0;
      regB <= 4'h0;
      srcMem <= 1'b0;
      srcImm <= 1'b0;
      dstMem <= 1'b0;
      eaSrc <= 32'h0000_0000;
      eaDst <= 32'h0000_0000;
      imm <= 32'h0000_0000;
      opA <= 32'h0000_0000;
      opB <= 32'h0000_0000;
      busData <= 32'h0000_0000;
      curAddr <= 32'h0000_0000;
      curIdx <= 4'h0;
      mask <= 16'h0000;
      beat <= 2'h0;
      wbValid <= 1'b0;
      wbIdx <= 4'h0;
      wbData <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      size <= next_size;
      regA <= next_regA;
      regB <= next_regB;
      srcMem <= next_srcMem;
      srcImm <= next_srcImm;
      dstMem <= next_dstMem;
      eaSrc <= next_eaSrc;
      eaDst <= next_eaDst;
      imm <= next_imm;
      opA <= next_opA;
      opB <= next_opB;
      busData <= next_busData;
      curAddr <= next_curAddr;
      curIdx <= next_curIdx;
      mask <= next_mask;
      beat <= next_beat;
      wbValid <= next_wbValid;
      wbIdx <= next_wbIdx;
      wbData <= next_wbData;
    end
  end
endmodule

// File: testbench/dmx_data_move_sva.sv
// Checker for the data movement unit, watching only its top ports.
// Assumes the bind below attaches it to every instance of the unit.
`timescale 1ns/1ps
module dmx_data_move_sva
  import dmx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire dmx_op_e opIn,
  input wire dmx_size_e sizeIn,
  input wire logic [3:0] regBIn,
  input wire logic [31:0] eaSrcIn,
  input wire logic [31:0] immIn,
  input wire logic memReq,
  input wire logic memAck,
  input wire logic memWrite,
  input wire dmx_size_e memSize,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic wbValid,
  input wire logic [3:0] wbIdx,
  input wire logic [31:0] wbData
);
  dmx_op_e capOp;
  dmx_size_e capSize;
  logic [3:0] capRegB;
  logic [31:0] capEa;
  logic [31:0] capImm;
  logic take;
  assign take = start && !busy;
  // Command fields are captured at the take edge, since the inputs may move on afterwards
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      capOp <= OP_GENERAL;
      capSize <= SZ_BYTE;
      capRegB <= 4'h0;
      capEa <= 32'h0;
      capImm <= 32'h0;
    end
    else if (take)
    begin
      capOp <= opIn;
      capSize <= sizeIn;
      capRegB <= regBIn;
      capEa <= eaSrcIn;
      capImm <= immIn;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  quick_sext_a: assert property (
    wbValid && capOp == OP_QUICK |-> wbIdx == capRegB && wbData == {{24{capImm[7]}}, capImm[7:0]})
    else $error("quick load result wrong");
  ea_load_a: assert property (
    wbValid && capOp == OP_EA_LOAD |-> wbIdx == capRegB && wbData == capEa)
    else $error("address load result wrong");
  addr_load_a: assert property (
    wbValid && capOp == OP_ADDR_LOAD |-> wbIdx == capRegB
      && (capSize != SZ_WORD || wbData[31:16] == {16{wbData[15]}}))
    else $error("address register load wrong");
  push_store_a: assert property (
    memReq && capOp == OP_EA_PUSH |-> memWrite && memSize == SZ_LONG && memWdata == capEa)
    else $error("push beat wrong");
  link_store_a: assert property (
    memReq && capOp == OP_LINK |-> memWrite && memSize == SZ_LONG)
    else $error("link beat wrong");
  unlink_read_a: assert property (
    memReq && capOp == OP_UNLINK |-> !memWrite && memSize == SZ_LONG)
    else $error("unlink beat wrong");
  periph_step_a: assert property (
    memReq && memAck && capOp == OP_PERIPH ##1 memReq
      |-> memSize == SZ_BYTE && memAddr == $past(memAddr) + 32'h2)
    else $error("peripheral address step wrong");
  req_hold_a: assert property (
    memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWrite) && $stable(memWdata))
    else $error("bus request changed before ack");
  done_bound_a: assert property (
    take |-> ##[1:300] done)
    else $error("command never completed");
  cover property (take && opIn == OP_PERIPH);
  cover property (take && opIn == OP_MULTI);
  cover property (memReq && !memAck);
endmodule

bind dmx_data_move dmx_data_move_sva i_sva (.*);

// File: testbench/dmx_mem_model.sv
// Behavioural memory and peripheral space on the unit's bus.
// Assumes right-aligned data; slowMode adds two wait cycles to every beat.
`timescale 1ns/1ps
module dmx_mem_model
  import dmx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic slowMode,
  input wire logic memReq,
  input wire logic memWrite,
  input wire dmx_size_e memSize,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  output logic memAck,
  output logic [31:0] memRdata
);
  logic [31:0] mem [0:4095];
  logic [1:0] waitCnt;
  logic [31:0] lastRd;
  logic [31:0] mask;
  assign mask = memSize == SZ_BYTE ? 32'hFF : memSize == SZ_WORD ? 32'hFFFF : 32'hFFFF_FFFF;
  assign memAck = memReq && waitCnt == (slowMode ? 2'h2 : 2'h0);
  // Outside an acknowledged read the lines toggle, so stale data can never pass
  assign memRdata = (memAck && !memWrite) ? (mem[memAddr[11:0]] & mask) : ~lastRd;
  always @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      waitCnt <= 2'h0;
      lastRd <= 32'h0;
    end
    else
    begin
      waitCnt <= (memReq && !memAck) ? waitCnt + 2'h1 : 2'h0;
      lastRd <= memRdata;
      if (memAck && memWrite)
        mem[memAddr[11:0]] <= memWdata & mask;
    end
  end
endmodule

// File: testbench/dmx_data_move_test.sv
// Self-checking bench for the data movement unit with a behavioural memory.
// Assumes the unit, its register file, the checker and the memory model compile first.
`timescale 1ns/1ps
module dmx_data_move_test;
  import dmx_pkg::*;
  typedef struct {dmx_op_e op; dmx_size_e sz; logic [3:0] rb; logic [31:0] imm;
    logic [31:0] ea; logic [31:0] exp;} dmx_row_s;
  logic clk_sys, reset, start, srcMemIn, srcImmIn, dstMemIn, busy, done, memReq, memWrite;
  logic memAck, wbValid, slowMode;
  dmx_op_e opIn;
  dmx_size_e sizeIn, memSize;
  logic [3:0] regAIn, regBIn, wbIdx, lastIdx;
  logic [31:0] eaSrcIn, eaDstIn, immIn, memAddr, memWdata, memRdata, wbData, lastWb;
  logic [15:0] regListIn;
  int n_fail = 0;
  int n_checks = 0;
  dmx_row_s rows [9];
  dmx_data_move i_dut (.*);
  dmx_mem_model i_mem (.*);
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (wbValid === 1'b1)
    begin
      lastIdx <= wbIdx;
      lastWb <= wbData;
    end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input dmx_op_e op, input dmx_size_e sz, input logic [3:0] ra,
    input logic [3:0] rb, input logic [2:0] fl, input logic [31:0] ea, input logic [31:0] imm);
    int k;
    @(negedge clk_sys);
    opIn = op;
    sizeIn = sz;
    regAIn = ra;
    regBIn = rb;
    {srcMemIn, srcImmIn, dstMemIn} = fl;
    eaSrcIn = ea;
    immIn = imm;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 400)
    begin
      @(negedge clk_sys);
      k++;
    end
    check({31'h0, done}, 32'h1);
    @(negedge clk_sys);
  endtask
  // Copies a register into D7 so its value shows on the write-back port
  task automatic expReg(input logic [3:0] idx, input logic [31:0] exp);
    cmd(OP_GENERAL, SZ_LONG, idx, 4'h7, 3'b000, 32'h0, 32'h0);
    check(lastWb, exp);
  endtask
  task automatic idleChk;
    check({28'h0, busy, done, memReq, wbValid}, 32'h0);
    check(wbData | {28'h0, wbIdx}, 32'h0);
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_fail++;
    summarize();
  end
  initial
  begin
    clk_sys = 1'b0;
    reset = 1'b1;
    {start, srcMemIn, srcImmIn, dstMemIn, slowMode} = 5'h0;
    opIn = OP_GENERAL;
    sizeIn = SZ_LONG;
    {regAIn, regBIn, regListIn} = 24'h0;
    {eaSrcIn, eaDstIn, immIn} = 96'h0;
    rows = '{
      '{OP_QUICK, SZ_LONG, 4'h3, 32'h80, 32'h0, 32'hFFFF_FF80},
      '{OP_QUICK, SZ_LONG, 4'h2, 32'h17F, 32'h0, 32'h7F},
      '{OP_ADDR_LOAD, SZ_WORD, 4'hC, 32'h8001, 32'h0, 32'hFFFF_8001},
      '{OP_ADDR_LOAD, SZ_LONG, 4'hA, 32'h1234_5678, 32'h0, 32'h1234_5678},
      '{OP_EA_LOAD, SZ_LONG, 4'hB, 32'h0, 32'hABC, 32'hABC},
      '{OP_GENERAL, SZ_LONG, 4'h2, 32'hAABB_CCDD, 32'h0, 32'hAABB_CCDD},
      '{OP_GENERAL, SZ_LONG, 4'hF, 32'h200, 32'h0, 32'h200},
      '{OP_GENERAL, SZ_LONG, 4'h1, 32'h1111_1111, 32'h0, 32'h1111_1111},
      '{OP_GENERAL, SZ_LONG, 4'h9, 32'hABCD_0000, 32'h0, 32'hABCD_0000}};
    repeat (6) @(negedge clk_sys);
    idleChk();
    reset = 1'b0;
    foreach (rows[i])
    begin
      cmd(rows[i].op, rows[i].sz, 4'h0, rows[i].rb, 3'b010, rows[i].ea, rows[i].imm);
      check({28'h0, lastIdx}, {28'h0, rows[i].rb});
      check(lastWb, rows[i].exp);
    end
    cmd(OP_SWAP, SZ_LONG, 4'h1, 4'h9, 3'b000, 32'h0, 32'h0);
    expReg(4'h1, 32'hABCD_0000);
    expReg(4'h9, 32'h1111_1111);
    slowMode = 1'b1;
    i_mem.mem[12'h100] = 32'h12;
    cmd(OP_GENERAL, SZ_BYTE, 4'h0, 4'h2, 3'b100, 32'h100, 32'h0);
    check(lastWb, 32'hAABB_CC12);
    eaDstIn = 32'h120;
    cmd(OP_GENERAL, SZ_LONG, 4'h2, 4'h0, 3'b001, 32'h0, 32'h0);
    check(i_mem.mem[12'h120], 32'hAABB_CC12);
    eaDstIn = 32'h130;
    cmd(OP_GENERAL, SZ_WORD, 4'h0, 4'h0, 3'b101, 32'h120, 32'h0);
    check(i_mem.mem[12'h130], 32'hCC12);
    cmd(OP_EA_PUSH, SZ_LONG, 4'h0, 4'h0, 3'b000, 32'h1234, 32'h0);
    check(i_mem.mem[12'h1FC], 32'h1234);
    expReg(4'hF, 32'h1FC);
    cmd(OP_LINK, SZ_LONG, 4'h9, 4'h0, 3'b000, 32'h0, 32'hFFFF_FFF8);
    check(i_mem.mem[12'h1F8], 32'h1111_1111);
    expReg(4'h9, 32'h1F8);
    expReg(4'hF, 32'h1F0);
    cmd(OP_UNLINK, SZ_LONG, 4'h9, 4'h0, 3'b000, 32'h0, 32'h0);
    expReg(4'h9, 32'h1111_1111);
    expReg(4'hF, 32'h1FC);
    regListIn = 16'h0006;
    cmd(OP_MULTI, SZ_LONG, 4'h0, 4'h0, 3'b001, 32'h300, 32'h0);
    check(i_mem.mem[12'h300], 32'hABCD_0000);
    check(i_mem.mem[12'h304], 32'hAABB_CC12);
    i_mem.mem[12'h310] = 32'h9000;
    i_mem.mem[12'h312] = 32'h1234;
    regListIn = 16'h0060;
    cmd(OP_MULTI, SZ_WORD, 4'h0, 4'h0, 3'b000, 32'h310, 32'h0);
    expReg(4'h5, 32'hFFFF_9000);
    expReg(4'h6, 32'h1234);
    cmd(OP_PERIPH, SZ_LONG, 4'h2, 4'h0, 3'b001, 32'h400, 32'h0);
    check({i_mem.mem[12'h400][7:0], i_mem.mem[12'h402][7:0], i_mem.mem[12'h404][7:0],
      i_mem.mem[12'h406][7:0]}, 32'hAABB_CC12);
    i_mem.mem[12'h500] = 32'h55;
    i_mem.mem[12'h502] = 32'h66;
    cmd(OP_PERIPH, SZ_WORD, 4'h2, 4'h0, 3'b000, 32'h500, 32'h0);
    check(lastWb, 32'hAABB_5566);
    cmd(OP_ADDR_LOAD, SZ_WORD, 4'h0, 4'hD, 3'b100, 32'h310, 32'h0);
    check(lastWb, 32'hFFFF_9000);
    i_mem.mem[12'h504] = 32'h77;
    i_mem.mem[12'h506] = 32'h88;
    cmd(OP_PERIPH, SZ_LONG, 4'h3, 4'h0, 3'b000, 32'h500, 32'h0);
    check(lastWb, 32'h5566_7788);
    // Abort a peripheral transfer mid-beat; registers must come back cleared
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    repeat (3) @(negedge clk_sys);
    reset = 1'b1;
    @(negedge clk_sys);
    idleChk();
    reset = 1'b0;
    expReg(4'h2, 32'h0);
    summarize();
  end
endmodule
